// file: hdl/ddrodt_pkg.sv
package ddrodt_pkg;
  // Link clock made by the controller from core_clk.
  localparam int CORE_PERIOD_NS = 8;
  localparam int LINK_PERIOD_NS = 160;
  localparam int CK_HALF_CYC = LINK_PERIOD_NS / CORE_PERIOD_NS / 2;
  // Latency terms, in link clock cycles.
  localparam logic [5:0] LAT_OFFSET = 6'h02;
  localparam logic [5:0] LAT_MIN = 6'h01;
  localparam logic [5:0] CWN4_EXTRA = 6'h04;
  localparam logic [5:0] CWN8_EXTRA = 6'h06;
  localparam logic [3:0] ODTH4 = 4'h4;
  localparam logic [3:0] ODTH8 = 4'h6;
  localparam int HIST_DEPTH = 40;
  localparam int READ_QUIET = 8;
  // Controller register map, byte addresses.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int CTRL_ODT_BIT = 0;
  localparam int CTRL_BC4_BIT = 1;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int STAT_ODT_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_QUIET_BIT = 2;
  localparam int STAT_CK_BIT = 3;
endpackage

// file: hdl/ddrodt_link_if.sv
`timescale 1ns/1ps
// Link between memory controller and termination logic.
interface ddrodt_link_if;
  logic ck;
  logic odt;
  logic wr_cmd;
  logic wr_bc4;
  modport dev
  (
    input ck,
    input odt,
    input wr_cmd,
    input wr_bc4
  );
  modport ctl
  (
    output ck,
    output odt,
    output wr_cmd,
    output wr_bc4
  );
endinterface

// file: hdl/ddrodt_term.sv
`timescale 1ns/1ps
// Summary of operation
// - Termination enabled when any strength bit set.
// - ODT low means off, high means on.
// - On/off uses only ODT and mode; here dq_driving also forces termination off.
// - Synchronous timing whenever DLL runs locked.
// - Controller disables termination in DLL-off mode.
// - On/off follows ODT after fixed latency.
// - Latency equals CWL plus AL minus two.
// - Controller holds ODT high four cycles.
// - After write, hold ODT four or six.
// - Controller drops ODT around reads.
// - Termination resumes once output drivers stop.
// - Dynamic mode when write strength bits set.
// - Without writes, nominal strength is used.
// - Write switches to write strength after latency.
// - Nominal returns after 4/6 plus latency.
// - Controller clears write strength in DLL-off.
// - Strength change lands half clock later.
// - ODT ignored when disabled or self-refreshing.
// - Frozen-DLL power-down uses direct, unlatched ODT.
module ddrodt_term #(
  parameter int HIST = ddrodt_pkg::HIST_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  ddrodt_link_if.dev lnk,
  input wire logic [2:0] rtt_nom_bits,
  input wire logic [1:0] rtt_wr_bits,
  input wire logic [3:0] cwl,
  input wire logic [3:0] al,
  input wire logic dll_frozen_pd,
  input wire logic self_refresh,
  input wire logic dq_driving,
  output logic rtt_on,
  output logic rtt_sel_wr,
  output logic [2:0] rtt_code
);

  // All state in one word: link samplers, latency histories and outputs.
  typedef struct packed {
    logic ck_meta;
    logic ck_sync;
    logic ck_prev;
    logic odt_meta;
    logic odt_sync;
    logic wr_meta;
    logic wr_sync;
    logic bc4_meta;
    logic bc4_sync;
    logic [HIST-1:0] odt_hist;
    logic [HIST-1:0] wr4_hist;
    logic [HIST-1:0] wr8_hist;
    logic lat_on;
    logic wr_due;
    logic sel_wr;
    logic term_on;
    logic [2:0] code;
    logic [5:0] lat_q;
  } ddrodt_dev_t;

  // Current and next copy of the whole state.
  ddrodt_dev_t s_reg;
  ddrodt_dev_t s_next;

  // Turn-on, turn-off and strength-switch latency, never below one cycle.
  // A latency of zero would let termination race the very sample that asked for it.
  function automatic logic [5:0] odt_lat(input logic [3:0] c, input logic [3:0] a);
    logic [5:0] sum;
    sum = {2'h0, c} + {2'h0, a};
    if (sum > ddrodt_pkg::LAT_OFFSET + ddrodt_pkg::LAT_MIN - 6'h01)
    begin
      odt_lat = sum - ddrodt_pkg::LAT_OFFSET;
    end
    else
    begin
      odt_lat = ddrodt_pkg::LAT_MIN;
    end
  endfunction

  // Ages a history by one link cycle, newest sample in bit zero.
  function automatic logic [HIST-1:0] hist_push(input logic [HIST-1:0] h, input logic b);
    hist_push = {h[HIST-2:0], b};
  endfunction

  // True when some write in the history lies lat..lat+len-1 cycles back.
  // HIST must exceed the longest window, lat plus six; deeper costs only flops.
  function automatic logic in_window(input logic [HIST-1:0] h, input logic [5:0] lat,
                                     input logic [5:0] len);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < HIST; k++)
    begin
      if (h[k] && (6'(k) >= lat) && (6'(k) < lat + len))
      begin
        hit = 1'b1;
      end
    end
    in_window = hit;
  endfunction

  // Link edges, mode decode and the current latency, shared by every path below.
  logic rise;
  logic fall;
  logic term_enable;
  logic dyn_enable;
  logic accept_odt;
  logic [5:0] lat;

  // Edge detection reads only the second and third stages of the clock sampler.
  assign rise = s_reg.ck_sync & ~s_reg.ck_prev;
  assign fall = ~s_reg.ck_sync & s_reg.ck_prev;
  assign term_enable = (|rtt_nom_bits) | (|rtt_wr_bits);
  assign dyn_enable = |rtt_wr_bits;
  assign accept_odt = term_enable & ~self_refresh;
  assign lat = odt_lat(cwl, al);

  // One next-state process for the whole block.
  always_comb
  begin
    s_next = s_reg;
    // Two flops on every link pin; the first stage may be metastable, so
    // nothing but the second stage reads it.
    s_next.ck_meta = lnk.ck;
    s_next.ck_sync = s_reg.ck_meta;
    s_next.ck_prev = s_reg.ck_sync;
    s_next.odt_meta = lnk.odt;
    s_next.odt_sync = s_reg.odt_meta;
    s_next.wr_meta = lnk.wr_cmd;
    s_next.wr_sync = s_reg.wr_meta;
    s_next.bc4_meta = lnk.wr_bc4;
    s_next.bc4_sync = s_reg.bc4_meta;
    // Each link rise shifts every history; one bit per cycle keeps
    // overlapping ODT edges and back-to-back writes apart.
    if (rise)
    begin
      s_next.odt_hist = hist_push(s_reg.odt_hist, s_reg.odt_sync & accept_odt);
      s_next.wr4_hist = hist_push(s_reg.wr4_hist,
                                  s_reg.wr_sync & s_reg.bc4_sync & dyn_enable);
      s_next.wr8_hist = hist_push(s_reg.wr8_hist,
                                  s_reg.wr_sync & ~s_reg.bc4_sync & dyn_enable);
      s_next.lat_on = s_next.odt_hist[lat];
      // Write strength from lat to 4+lat or 6+lat cycles after the write.
      s_next.wr_due = in_window(s_next.wr4_hist, lat, ddrodt_pkg::CWN4_EXTRA) |
                      in_window(s_next.wr8_hist, lat, ddrodt_pkg::CWN8_EXTRA);
    end
    // A new latency makes every scheduled edge in the histories meaningless, so
    // they are dropped; otherwise old samples would switch termination on later
    // with no ODT request behind them.
    s_next.lat_q = lat;
    if (lat != s_reg.lat_q)
    begin
      s_next.odt_hist = '0;
      s_next.wr4_hist = '0;
      s_next.wr8_hist = '0;
      s_next.lat_on = 1'b0;
      s_next.wr_due = 1'b0;
    end
    // Strength changes land on the falling edge, half a clock late.
    if (fall)
    begin
      s_next.sel_wr = s_reg.wr_due;
    end
    // Frozen-DLL power-down follows the pin directly with no latency.
    // The power-down transition windows are not modelled: the switch is immediate.
    if (dll_frozen_pd)
    begin
      s_next.term_on = s_reg.odt_sync & accept_odt;
    end
    else
    begin
      s_next.term_on = s_reg.lat_on & accept_odt;
    end
    // The device cannot drive and terminate at once; resume when it stops.
    // The read side raises dq_driving for the whole burst, postamble included.
    if (dq_driving)
    begin
      s_next.term_on = 1'b0;
    end
    // Nominal strength unless a write window is active.
    // Using the next sel_wr keeps rtt_code and rtt_sel_wr switching together.
    if (s_next.sel_wr && dyn_enable)
    begin
      s_next.code = {1'b0, rtt_wr_bits};
    end
    else
    begin
      s_next.code = rtt_nom_bits;
    end
    // Reset and latency changes both clear the schedule.
    if (rst)
    begin
      s_next = '0;
    end
  end

  // State register.
  // Reset is folded into the next-state process, so this stays a plain register.
  always_ff @(posedge core_clk)
  begin
    s_reg <= s_next;
  end

  // Only the pin, the mode bits and dq_driving steer on/off; command decode never does.
  // Outputs come from flops, one gate at most, so the switches see no decode glitches.
  assign rtt_on = s_reg.term_on;
  assign rtt_sel_wr = s_reg.sel_wr & s_reg.term_on;
  assign rtt_code = s_reg.code;

endmodule

// file: hdl/ddrodt_ctl.sv
`timescale 1ns/1ps
// Controller end: drives link clock, ODT and write commands from APB registers.
module ddrodt_ctl #(
  parameter int CK_HALF = ddrodt_pkg::CK_HALF_CYC,
  parameter int QUIET = ddrodt_pkg::READ_QUIET
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ddrodt_link_if.ctl lnk
);

  typedef struct packed {
    logic [7:0] div;
    logic ck;
    logic odt;
    logic wr;
    logic bc4_out;
    logic [3:0] hold;
    logic [7:0] quiet;
    logic odt_req;
    logic bc4_mode;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] rdata;
  } ddrodt_ctl_t;

  ddrodt_ctl_t s_reg;
  ddrodt_ctl_t s_next;

  logic mapped;
  logic wr_acc;
  logic ck_fall;
  logic [3:0] wr_hold;

  assign mapped = (paddr == ddrodt_pkg::CTRL_OFS) || (paddr == ddrodt_pkg::CMD_OFS) ||
                  (paddr == ddrodt_pkg::STAT_OFS);
  assign wr_acc = psel & penable & pwrite & mapped;
  assign ck_fall = s_reg.ck && (s_reg.div == 8'(CK_HALF - 1));
  assign wr_hold = s_reg.bc4_mode ? ddrodt_pkg::ODTH4 : ddrodt_pkg::ODTH8;

  // Next state: divider, link sequencing on falling edges, then APB.
  always_comb
  begin
    s_next = s_reg;
    s_next.wr = s_reg.wr;
    if (s_reg.div == 8'(CK_HALF - 1))
    begin
      s_next.div = 8'h00;
      s_next.ck = ~s_reg.ck;
    end
    else
    begin
      s_next.div = s_reg.div + 8'h01;
    end
    // Link signals change on falling edges so the device sees them settled.
    if (ck_fall)
    begin
      s_next.wr = 1'b0;
      if (s_reg.hold != 4'h0)
      begin
        s_next.hold = s_reg.hold - 4'h1;
      end
      if (s_reg.quiet != 8'h00)
      begin
        s_next.quiet = s_reg.quiet - 8'h01;
      end
      if (s_reg.wr_pend && s_reg.quiet == 8'h00)
      begin
        // Writes go out with ODT high and stretch the hold time.
        s_next.wr = 1'b1;
        s_next.bc4_out = s_reg.bc4_mode;
        s_next.odt = 1'b1;
        s_next.wr_pend = 1'b0;
        if (!s_reg.odt || s_next.hold < wr_hold)
        begin
          s_next.hold = wr_hold;
        end
      end
      else if (s_reg.rd_pend && s_reg.hold == 4'h0)
      begin
        // A read waits for the hold, then keeps ODT low for its window.
        s_next.odt = 1'b0;
        s_next.quiet = 8'(QUIET);
        s_next.rd_pend = 1'b0;
      end
      else if (s_reg.quiet == 8'h00 && s_reg.odt_req && !s_reg.odt)
      begin
        s_next.odt = 1'b1;
        s_next.hold = ddrodt_pkg::ODTH4;
      end
      else if (!s_reg.odt_req && s_reg.odt && s_reg.hold == 4'h0)
      begin
        s_next.odt = 1'b0;
      end
    end
    // Read data is captured in the setup cycle so it is a flop in access.
    if (psel && !penable)
    begin
      case (paddr)
        ddrodt_pkg::CTRL_OFS:
          s_next.rdata = {30'h0, s_reg.bc4_mode, s_reg.odt_req};
        ddrodt_pkg::CMD_OFS:
          s_next.rdata = {30'h0, s_reg.rd_pend, s_reg.wr_pend};
        ddrodt_pkg::STAT_OFS:
          s_next.rdata = {28'h0, s_reg.ck, s_reg.quiet != 8'h00, s_reg.hold != 4'h0,
                          s_reg.odt};
        default:
          s_next.rdata = 32'h0;
      endcase
    end
    // A command set in the cycle its pending bit clears is kept.
    if (wr_acc && paddr == ddrodt_pkg::CTRL_OFS)
    begin
      s_next.odt_req = pwdata[ddrodt_pkg::CTRL_ODT_BIT];
      s_next.bc4_mode = pwdata[ddrodt_pkg::CTRL_BC4_BIT];
    end
    if (wr_acc && paddr == ddrodt_pkg::CMD_OFS)
    begin
      s_next.wr_pend = s_next.wr_pend | pwdata[ddrodt_pkg::CMD_WR_BIT];
      s_next.rd_pend = s_next.rd_pend | pwdata[ddrodt_pkg::CMD_RD_BIT];
    end
    if (rst)
    begin
      s_next = '0;
    end
  end

  // State register.
  always_ff @(posedge core_clk)
  begin
    s_reg <= s_next;
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s_reg.rdata;
  assign lnk.ck = s_reg.ck;
  assign lnk.odt = s_reg.odt;
  assign lnk.wr_cmd = s_reg.wr;
  assign lnk.wr_bc4 = s_reg.bc4_out;

endmodule

// file: dv/ddrodt_chk.sv
`timescale 1ns/1ps
module ddrodt_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ck,
  input wire logic odt,
  input wire logic wr_cmd,
  input wire logic wr_bc4
);
  logic ck_q;
  logic odt_s;
  logic bc4_s;
  logic [2:0] hcnt;
  logic [2:0] wcnt;
  wire logic rise = ck & ~ck_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Mirror what the device registers at each link rise; counters saturate so long gaps stay legal.
  always_ff @(posedge core_clk)
  begin
    ck_q <= rst ? 1'b0 : ck;
    if (rst)
    begin
      odt_s <= 1'b0;
      hcnt <= 3'h7;
      wcnt <= 3'h7;
      bc4_s <= 1'b0;
    end
    else if (rise)
    begin
      odt_s <= odt;
      hcnt <= (odt && !odt_s) ? 3'h0 : hcnt + {2'h0, hcnt != 3'h7};
      wcnt <= (wr_cmd && odt) ? 3'h0 : wcnt + {2'h0, wcnt != 3'h7};
      bc4_s <= wr_cmd ? wr_bc4 : bc4_s;
    end
  end
  sequence s_drop;
    rise && odt_s && !odt;
  endsequence
  sequence s_wr;
    rise && wr_cmd;
  endsequence
  property p_odth4;
    s_drop |-> hcnt >= 3'h3;
  endproperty
  a_odth4: assert property (p_odth4)
    else $error("odt low too soon after raise");
  property p_odth_wr;
    s_drop |-> wcnt >= (bc4_s ? 3'h3 : 3'h5);
  endproperty
  a_odth_wr: assert property (p_odth_wr)
    else $error("odt low too soon after write");
  property p_wr_odt;
    s_wr |-> odt;
  endproperty
  a_wr_odt: assert property (p_wr_odt)
    else $error("write sent without odt");
  property p_ck_high;
    ck && ck_q |-> $stable(odt) && $stable(wr_cmd);
  endproperty
  a_ck_high: assert property (p_ck_high)
    else $error("link changed while ck high");
  property p_bc4;
    wr_cmd && $past(wr_cmd) |-> $stable(wr_bc4);
  endproperty
  a_bc4: assert property (p_bc4)
    else $error("burst mode changed during write");
  // Link pins may move only with a ck fall, so every rise samples settled levels.
  sequence s_link_move;
    $changed(odt) || $changed(wr_cmd) || $changed(wr_bc4);
  endsequence
  property p_on_fall;
    s_link_move |-> !ck && ck_q;
  endproperty
  a_on_fall: assert property (p_on_fall)
    else $error("link changed away from a ck fall");
endmodule

// file: dv/ddr3_odt_control_tb_top.sv
`timescale 1ns/1ps
module ddr3_odt_control_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] nom = 3'h1;
  logic [1:0] wrb = 2'h0;
  logic [3:0] cwl = 4'h5;
  logic [3:0] al = 4'h0;
  logic frz = 1'b0;
  logic sr = 1'b0;
  logic dq = 1'b0;
  logic rtt_on;
  logic rtt_sel_wr;
  logic [2:0] rtt_code;
  logic ckq = 1'b0;
  logic err;
  logic [31:0] r;
  int n;
  int m;
  int errors = 0;
  int comparisons = 0;
  ddrodt_link_if lnk();
  wire logic [3:0] sv = {rtt_sel_wr, rtt_on, lnk.wr_cmd, lnk.odt};
  // A link clock twice the default rate keeps the run short; a five-cycle half period
  // still covers the device's three-cycle sampler and its two register stages.
  ddrodt_ctl #(.CK_HALF(5)) ddrodt_ctl_inst (.core_clk(core_clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  ddrodt_term ddrodt_term_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk), .rtt_nom_bits(nom),
    .rtt_wr_bits(wrb), .cwl(cwl), .al(al), .dll_frozen_pd(frz), .self_refresh(sr),
    .dq_driving(dq), .rtt_on(rtt_on), .rtt_sel_wr(rtt_sel_wr), .rtt_code(rtt_code));
  ddrodt_chk ddrodt_chk_inst (.core_clk(core_clk), .rst(rst), .ck(lnk.ck), .odt(lnk.odt),
    .wr_cmd(lnk.wr_cmd), .wr_bc4(lnk.wr_bc4));
  // Core clock and a one-cycle copy of the link clock to spot its rises.
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) ckq <= lnk.ck;
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; the leading edge keeps two transfers from touching psel in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for a watched signal to reach v, counting link rises; -1 means it never came.
  task automatic wt(input int s, input logic v, output int c);
    c = 0;
    repeat (400)
    begin
      @(posedge core_clk);
      #1;
      if (lnk.ck && !ckq) c++;
      if (sv[s] === v) return;
    end
    c = -1;
  endtask
  task t_reg;
    apb(1'b0, ddrodt_pkg::STAT_OFS, 32'h0, r);
    chk(r & 32'h7, 32'h0);
    apb(1'b0, 8'hFC, 32'h0, r);
    chk(r, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h2, r);
    apb(1'b0, ddrodt_pkg::CTRL_OFS, 32'h0, r);
    chk(r, 32'h2);
  endtask
  task t_lat;
    logic [3:0] c[3] = '{4'h5, 4'h5, 4'h2};
    logic [3:0] a[3] = '{4'h0, 4'h4, 4'h0};
    int e;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      cwl <= c[i];
      al <= a[i];
      e = int'(c[i]) + int'(a[i]) - 2;
      if (e < 1) e = 1;
      apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h1, r);
      wt(0, 1'b1, n);
      wt(2, 1'b1, n);
      chk(n, e + 1);
      chk(rtt_code, 3'h1);
      chk(rtt_sel_wr, 1'b0);
      apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h0, r);
      wt(0, 1'b0, n);
      wt(2, 1'b0, n);
      chk(n, e + 1);
    end
    @(posedge core_clk);
    cwl <= 4'h5;
    al <= 4'h0;
  endtask
  task t_en;
    logic [2:0] b[3] = '{3'h0, 3'h0, 3'h1};
    logic [1:0] w[3] = '{2'h0, 2'h1, 2'h0};
    logic x[3] = '{1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      nom <= b[i];
      wrb <= w[i];
      sr <= (i == 2);
      apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h1, r);
      wt(0, 1'b1, n);
      wt(2, 1'b1, n);
      chk(n, x[i] ? 4 : -1);
      apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h0, r);
      wt(0, 1'b0, n);
      wt(2, 1'b0, n);
    end
    @(posedge core_clk);
    nom <= 3'h1;
    sr <= 1'b0;
  endtask
  task t_dyn;
    for (int b = 0; b < 2; b++)
    begin
      @(posedge core_clk);
      wrb <= 2'h2;
      apb(1'b1, ddrodt_pkg::CTRL_OFS, b ? 32'h2 : 32'h0, r);
      apb(1'b1, ddrodt_pkg::CMD_OFS, 32'h1, r);
      wt(1, 1'b1, n);
      wt(3, 1'b1, n);
      chk(n, 4);
      chk(rtt_code, 3'h2);
      wt(3, 1'b0, m);
      chk(n + m, b ? 8 : 10);
      wt(0, 1'b0, n);
      wt(2, 1'b0, n);
    end
  endtask
  // Output drivers win over termination; frozen DLL then drops the latency altogether.
  task t_misc;
    apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h1, r);
    wt(2, 1'b1, n);
    @(posedge core_clk);
    dq <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(rtt_on, 1'b0);
    @(posedge core_clk);
    dq <= 1'b0;
    frz <= 1'b1;
    al <= 4'h4;
    repeat (3) @(posedge core_clk);
    #1 chk(rtt_on, 1'b1);
    apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h0, r);
    wt(0, 1'b0, n);
    wt(2, 1'b0, n);
    chk(n, 0);
  endtask
  // A read window pulls the pin low for the quiet span even while ODT stays requested.
  task t_rd;
    apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h1, r);
    wt(0, 1'b1, n);
    apb(1'b1, ddrodt_pkg::CMD_OFS, 32'h2, r);
    wt(0, 1'b0, n);
    apb(1'b0, ddrodt_pkg::STAT_OFS, 32'h0, r);
    chk(r & 32'h5, 32'h4);
    wt(0, 1'b1, n);
    chk(n, ddrodt_pkg::READ_QUIET + 1);
    apb(1'b1, ddrodt_pkg::CTRL_OFS, 32'h0, r);
    wt(0, 1'b0, n);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reg();
    t_lat();
    t_en();
    t_dyn();
    t_misc();
    t_rd();
    results();
  end
  // Watchdog well past the few thousand cycles the scenarios need.
  initial
  begin
    repeat (50000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule
